/* File: hdl/ssw_supervisor.v */
// Purpose: supply switchover, power-on and low-voltage reset, bus-kicked watchdog
// Assumes: comparator results as async levels; scl/sda sampled synchronously at mclk
// Notes: long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "ssw_map.vh"
// Summary of operation
// - Standard policy: enter battery only when supply below battery-hys and below trip.
// - Standard policy: leave battery when supply above battery+hys or trip+hys.
// - Select bit at zero selects the standard switchover policy.
// - Select bit at one: legacy, run from higher source with battery hysteresis.
// - Power-on holds reset until supply above reset threshold for 250 ms.
// - Memory-reaching communication is refused while power-on reset is active.
// - Period field: 11 off, 10 250 ms, 01 750 ms, 00 1.75 s.
// - Disabled period puts the watchdog into an idle, non-counting state.
// - START is sda falling while scl high; it kicks the watchdog.
// - Each START while out of reset reloads the watchdog counter to the full period.
// - Watchdog expiry asserts reset for one reset timeout period.
// - START during a reset timeout period has no effect.
// - Watchdog is disabled while running from battery.
// - Low-voltage reset held while below threshold, released 250 ms after rising.
// - Outside battery mode an ongoing memory write completes despite low-voltage reset.
// - Low-voltage reset aborts serial transactions and blocks new ones until release.
// - A low-voltage reset begun in battery mode stays low until back on main supply.
module ssw_supervisor #(
   parameter [`SSW_CNT_W-1:0] RESET_TIMEOUT_CYC = `SSW_RESET_TIMEOUT_CYC,
   parameter [`SSW_CNT_W-1:0] WD_SHORT_CYC = `SSW_WD_SHORT_CYC,
   parameter [`SSW_CNT_W-1:0] WD_MID_CYC = `SSW_WD_MID_CYC,
   parameter [`SSW_CNT_W-1:0] WD_LONG_CYC = `SSW_WD_LONG_CYC
) (
   input wire mclk,
   input wire rst,
   input wire cmp_vdd_below_bat_minus_hys,
   input wire cmp_vdd_above_bat_plus_hys,
   input wire cmp_vdd_below_trip,
   input wire cmp_vdd_above_trip_plus_hys,
   input wire cmp_vdd_above_reset,
   input wire battery_switch_select,
   input wire watchdog_period_bit_high,
   input wire watchdog_period_bit_low,
   input wire scl_in,
   input wire sda_in,
   input wire nv_write_busy,
   output wire battery_mode,
   output wire reset_n_out,
   output wire reset_n_oe_n,
   output wire bus_enable,
   output wire bus_abort,
   output wire nv_write_allow,
   output wire start_seen,
   output wire stop_seen,
   output wire watchdog_running
);
   localparam [3:0] ST_POR = 4'h1;
   localparam [3:0] ST_RUN = 4'h2;
   localparam [3:0] ST_LVR = 4'h4;
   localparam [3:0] ST_WDR = 4'h8;

   wire [4:0] cmp_sync;
   wire below_bat;
   wire above_bat;
   wire below_trip;
   wire above_trip;
   wire above_reset;

   ssw_sync #(
      .WIDTH(5)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .async_in({cmp_vdd_below_bat_minus_hys, cmp_vdd_above_bat_plus_hys,
                 cmp_vdd_below_trip, cmp_vdd_above_trip_plus_hys, cmp_vdd_above_reset}),
      .sync_out(cmp_sync)
   );

   assign below_bat = cmp_sync[4];
   assign above_bat = cmp_sync[3];
   assign below_trip = cmp_sync[2];
   assign above_trip = cmp_sync[1];
   assign above_reset = cmp_sync[0];

   // Supply mode
   reg bat_mode_reg;
   reg bat_mode_next;

   always @* begin
      bat_mode_next = bat_mode_reg;
      if (!battery_switch_select) begin
         if (!bat_mode_reg && below_bat && below_trip) begin
            bat_mode_next = 1'b1;
         end else if (bat_mode_reg && (above_bat || above_trip)) begin
            bat_mode_next = 1'b0;
         end
      end else begin
         if (!bat_mode_reg && below_bat) begin
            bat_mode_next = 1'b1;
         end else if (bat_mode_reg && above_bat) begin
            bat_mode_next = 1'b0;
         end
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         bat_mode_reg <= 1'b0;
      end else begin
         bat_mode_reg <= bat_mode_next;
      end
   end

   // Bus condition detection on sampled lines
   reg scl_d_reg;
   reg sda_d_reg;
   wire start_evt;
   wire stop_evt;

   always @(posedge mclk) begin
      if (rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_in;
         sda_d_reg <= sda_in;
      end
   end

   assign start_evt = scl_d_reg && scl_in && sda_d_reg && !sda_in;
   assign stop_evt = scl_d_reg && scl_in && !sda_d_reg && sda_in;

   // Watchdog period select
   wire [1:0] wd_sel;
   reg [`SSW_CNT_W-1:0] wd_period;
   wire wd_enabled;

   assign wd_sel = {watchdog_period_bit_high, watchdog_period_bit_low};

   always @* begin
      case (wd_sel)
         `SSW_WD_SHORT: wd_period = WD_SHORT_CYC;
         `SSW_WD_MID: wd_period = WD_MID_CYC;
         `SSW_WD_LONG: wd_period = WD_LONG_CYC;
         default: wd_period = {`SSW_CNT_W{1'b0}};
      endcase
   end

   assign wd_enabled = (wd_sel != `SSW_WD_OFF) && !bat_mode_reg;

   // Reset sequencer
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [`SSW_CNT_W-1:0] rst_cnt_reg;
   reg [`SSW_CNT_W-1:0] rst_cnt_next;
   reg [`SSW_CNT_W-1:0] wd_cnt_reg;
   reg [`SSW_CNT_W-1:0] wd_cnt_next;
   reg bat_low_latch_reg;
   reg bat_low_latch_next;
   wire hold_low;

   // Battery-mode dip keeps reset low until main supply returns, regardless of recovery
   assign hold_low = !above_reset || bat_low_latch_reg;

   always @* begin
      bat_low_latch_next = bat_low_latch_reg;
      if (bat_mode_reg && !above_reset) begin
         bat_low_latch_next = 1'b1;
      end else if (!bat_mode_reg) begin
         bat_low_latch_next = 1'b0;
      end
   end

   always @* begin
      state_next = state_reg;
      rst_cnt_next = rst_cnt_reg;
      wd_cnt_next = wd_cnt_reg;
      case (state_reg)
         ST_POR: begin
            if (hold_low) begin
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
            end else if (rst_cnt_reg >= RESET_TIMEOUT_CYC - 1'b1) begin
               state_next = ST_RUN;
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
               wd_cnt_next = wd_period;
            end else begin
               rst_cnt_next = rst_cnt_reg + 1'b1;
            end
         end
         ST_RUN: begin
            if (hold_low) begin
               state_next = ST_LVR;
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
            end else if (!wd_enabled) begin
               wd_cnt_next = wd_period;
            end else if (start_evt) begin
               wd_cnt_next = wd_period;
            end else if (wd_cnt_reg == {`SSW_CNT_W{1'b0}} || wd_cnt_reg > wd_period) begin
               // Just enabled or period shortened: start a full period, never a false expiry
               wd_cnt_next = wd_period;
            end else if (wd_cnt_reg <= 1) begin
               state_next = ST_WDR;
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
            end else begin
               wd_cnt_next = wd_cnt_reg - 1'b1;
            end
         end
         ST_LVR: begin
            if (hold_low) begin
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
            end else if (rst_cnt_reg >= RESET_TIMEOUT_CYC - 1'b1) begin
               state_next = ST_RUN;
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
               wd_cnt_next = wd_period;
            end else begin
               rst_cnt_next = rst_cnt_reg + 1'b1;
            end
         end
         ST_WDR: begin
            // Starts are ignored here; counter reloads only at pulse end
            if (hold_low) begin
               state_next = ST_LVR;
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
            end else if (rst_cnt_reg >= RESET_TIMEOUT_CYC - 1'b1) begin
               state_next = ST_RUN;
               rst_cnt_next = {`SSW_CNT_W{1'b0}};
               wd_cnt_next = wd_period;
            end else begin
               rst_cnt_next = rst_cnt_reg + 1'b1;
            end
         end
         default: begin
            state_next = ST_POR;
            rst_cnt_next = {`SSW_CNT_W{1'b0}};
         end
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         state_reg <= ST_POR;
         rst_cnt_reg <= {`SSW_CNT_W{1'b0}};
         wd_cnt_reg <= {`SSW_CNT_W{1'b0}};
         bat_low_latch_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rst_cnt_reg <= rst_cnt_next;
         wd_cnt_reg <= wd_cnt_next;
         bat_low_latch_reg <= bat_low_latch_next;
      end
   end

   // Registered outputs
   reg reset_act_reg;
   reg bus_en_reg;
   reg abort_reg;
   reg nv_allow_reg;
   reg start_reg;
   reg stop_reg;
   reg wd_run_reg;
   reg lvr_prev_reg;
   wire in_lvr;

   assign in_lvr = (state_next == ST_LVR);

   always @(posedge mclk) begin
      if (rst) begin
         reset_act_reg <= 1'b1;
         bus_en_reg <= 1'b0;
         abort_reg <= 1'b0;
         nv_allow_reg <= 1'b0;
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
         wd_run_reg <= 1'b0;
         lvr_prev_reg <= 1'b0;
      end else begin
         reset_act_reg <= (state_next != ST_RUN);
         // Bus blocked during power-on and low-voltage reset only
         bus_en_reg <= (state_next != ST_POR) && !in_lvr;
         abort_reg <= in_lvr && !lvr_prev_reg;
         // Write in flight may finish under low-voltage reset unless on battery
         nv_allow_reg <= (state_next == ST_RUN) || (state_next == ST_WDR) ||
                         (in_lvr && nv_write_busy && !bat_mode_next);
         start_reg <= start_evt;
         stop_reg <= stop_evt;
         wd_run_reg <= (state_next == ST_RUN) && wd_enabled;
         lvr_prev_reg <= in_lvr;
      end
   end

   assign battery_mode = bat_mode_reg;
   assign reset_n_out = 1'b0;
   // Open drain: enable low pulls the line low
   assign reset_n_oe_n = !reset_act_reg;
   assign bus_enable = bus_en_reg;
   assign bus_abort = abort_reg;
   assign nv_write_allow = nv_allow_reg;
   assign start_seen = start_reg;
   assign stop_seen = stop_reg;
   assign watchdog_running = wd_run_reg;
endmodule

/* File: hdl/ssw_sync.v */
// Purpose: two-flop synchronisers for the comparator results
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module ssw_sync #(
   parameter WIDTH = 5
) (
   input wire mclk,
   input wire rst,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_reg;
         reg stable_reg;
         always @(posedge mclk) begin
            if (rst) begin
               meta_reg <= 1'b0;
               stable_reg <= 1'b0;
            end else begin
               meta_reg <= async_in[i];
               stable_reg <= meta_reg;
            end
         end
         assign sync_out[i] = stable_reg;
      end
   endgenerate
endmodule

/* File: pkg/ssw_map.vh */
// Purpose: constants for the supply supervisor and watchdog
// Assumes: 200 MHz mclk
// Notes: times in their own unit, counts derived from the clock rate
`ifndef SSW_MAP_VH
`define SSW_MAP_VH
`define SSW_CLK_MHZ 200
`define SSW_RESET_TIMEOUT_MS 250
`define SSW_WD_SHORT_MS 250
`define SSW_WD_MID_MS 750
`define SSW_WD_LONG_MS 1750
`define SSW_RESET_TIMEOUT_CYC (`SSW_RESET_TIMEOUT_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_SHORT_CYC (`SSW_WD_SHORT_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_MID_CYC (`SSW_WD_MID_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_LONG_CYC (`SSW_WD_LONG_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_WD_OFF 2'h3
`define SSW_WD_SHORT 2'h2
`define SSW_WD_MID 2'h1
`define SSW_WD_LONG 2'h0
`define SSW_CNT_W 32
`endif

/* File: verification/ssw_host.sv */
// Purpose: host side of the two-wire bus
// Assumes: lines idle high through pull-ups
// Notes: only START and STOP are produced, no bytes
`timescale 1ns/1ps
module ssw_host (
   input wire mclk,
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // A lone START is always closed by a STOP so the slave returns to standby
   task kick;
      @(negedge mclk);
      sda = 1'h0;
      repeat (2) @(negedge mclk);
      sda = 1'h1;
   endtask
endmodule

/* File: verification/ssw_props.sv */
// Purpose: timing checks on the supervisor ports
// Assumes: 2-flop sync plus one register stage before mode and reset outputs
// Notes: bound into every supervisor instance
`timescale 1ns/1ps
module ssw_props (
   input wire mclk,
   input wire rst,
   input wire cmp_vdd_below_bat_minus_hys,
   input wire cmp_vdd_above_bat_plus_hys,
   input wire cmp_vdd_below_trip,
   input wire cmp_vdd_above_trip_plus_hys,
   input wire cmp_vdd_above_reset,
   input wire battery_switch_select,
   input wire watchdog_period_bit_high,
   input wire watchdog_period_bit_low,
   input wire battery_mode,
   input wire reset_n_oe_n,
   input wire bus_enable,
   input wire start_seen,
   input wire watchdog_running
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // At least one spare cycle in each window covers the sync stages after reset
   a_std_enter: assert property ((!battery_switch_select && cmp_vdd_below_trip
      && cmp_vdd_below_bat_minus_hys)[*4] |=> battery_mode) else $error("no battery entry");
   a_std_stay: assert property ((!battery_mode && !battery_switch_select
      && !cmp_vdd_below_trip)[*4] |=> !battery_mode) else $error("early battery entry");
   a_std_exit: assert property ((!battery_switch_select
      && cmp_vdd_above_trip_plus_hys)[*4] |=> !battery_mode) else $error("no supply return");
   a_leg_enter: assert property ((battery_switch_select
      && cmp_vdd_below_bat_minus_hys)[*4] |=> battery_mode) else $error("no legacy entry");
   a_leg_exit: assert property ((battery_switch_select
      && cmp_vdd_above_bat_plus_hys)[*4] |=> !battery_mode) else $error("no legacy exit");
   a_lvr_hold: assert property ((!cmp_vdd_above_reset)[*5] |=> !reset_n_oe_n)
      else $error("reset not held while low");
   a_lvr_bus: assert property ((!cmp_vdd_above_reset)[*5] |=> !bus_enable)
      else $error("bus open while low");
   a_wd_off: assert property (({watchdog_period_bit_high, watchdog_period_bit_low}
      == 2'h3)[*3] |=> !watchdog_running) else $error("watchdog counts while off");
   a_batt_wd: assert property (battery_mode[*3] |=> !watchdog_running)
      else $error("watchdog runs on battery");
   a_start_once: assert property (start_seen |=> !start_seen)
      else $error("start pulse too long");
endmodule
bind ssw_supervisor ssw_props i_ssw_props (
   .mclk(mclk),
   .rst(rst),
   .cmp_vdd_below_bat_minus_hys(cmp_vdd_below_bat_minus_hys),
   .cmp_vdd_above_bat_plus_hys(cmp_vdd_above_bat_plus_hys),
   .cmp_vdd_below_trip(cmp_vdd_below_trip),
   .cmp_vdd_above_trip_plus_hys(cmp_vdd_above_trip_plus_hys),
   .cmp_vdd_above_reset(cmp_vdd_above_reset),
   .battery_switch_select(battery_switch_select),
   .watchdog_period_bit_high(watchdog_period_bit_high),
   .watchdog_period_bit_low(watchdog_period_bit_low),
   .battery_mode(battery_mode),
   .reset_n_oe_n(reset_n_oe_n),
   .bus_enable(bus_enable),
   .start_seen(start_seen),
   .watchdog_running(watchdog_running)
);

/* File: verification/tb.sv */
// Purpose: self-checking bench for the supervisor
// Assumes: shortened counts 20/40/60/80 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module tb;
   logic mclk = 0, rst = 1, bbm = 0, bbp = 1, bt = 0, tp = 1, vr = 1;
   logic bss = 0, wh = 1, wl = 1, nvb = 0, ab_seen = 0;
   wire scl, sda, bm, rno, roe, ben, bab, nva, sts, sps, wdr;
   int err_total = 0, samples_checked = 0, n, n_start = 0, n_stop = 0;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (bab === 1'b1) ab_seen = 1;
      if (sts === 1'b1) n_start++;
      if (sps === 1'b1) n_stop++;
   end
   ssw_host i_ssw_host (.mclk(mclk), .scl(scl), .sda(sda));
   ssw_supervisor #(.RESET_TIMEOUT_CYC(32'h14), .WD_SHORT_CYC(32'h28), .WD_MID_CYC(32'h3C),
      .WD_LONG_CYC(32'h50)) i_ssw_supervisor (.mclk(mclk), .rst(rst),
      .cmp_vdd_below_bat_minus_hys(bbm), .cmp_vdd_above_bat_plus_hys(bbp),
      .cmp_vdd_below_trip(bt), .cmp_vdd_above_trip_plus_hys(tp), .cmp_vdd_above_reset(vr),
      .battery_switch_select(bss), .watchdog_period_bit_high(wh),
      .watchdog_period_bit_low(wl), .scl_in(scl), .sda_in(sda), .nv_write_busy(nvb),
      .battery_mode(bm), .reset_n_out(rno), .reset_n_oe_n(roe), .bus_enable(ben),
      .bus_abort(bab), .nv_write_allow(nva), .start_seen(sts), .stop_seen(sps),
      .watchdog_running(wdr));
   task chk(input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %b want %b", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cy(input int k);
      repeat (k) @(negedge mclk);
   endtask
   // Counts edges until the reset pin reaches lvl; overrun ends the run
   task wt(input logic lvl, input int lim);
      n = 0;
      while (roe !== lvl) begin
         @(posedge mclk);
         #1;
         n++;
         if (n > lim) begin
            err_total++;
            summarize;
         end
      end
   endtask
   task t_wd;
      for (int i = 0; i < 3; i++) begin
         cy(1);
         {wh, wl} = 2'(2 - i);
         repeat (3) begin
            i_ssw_host.kick;
            cy(30 + 20 * i);
         end
         chk(roe, 1);
         chk(wdr, 1);
         i_ssw_host.kick;
         wt(0, 120);
         chk(n >= 34 + 20 * i && n <= 44 + 20 * i, 1);
         // A START that restarted the pulse would stretch it past 18 counted edges
         i_ssw_host.kick;
         wt(1, 40);
         chk(n >= 17 && n <= 18, 1);
      end
      cy(1);
      {wh, wl} = 2'h3;
      cy(150);
      chk(roe, 1);
      chk(wdr, 0);
      chk(n_start == 15, 1);
      chk(n_stop == 15, 1);
   endtask
   task t_sw;
      cy(1);
      {wh, wl} = 2'h2;
      i_ssw_host.kick;
      bbm = 1;
      bbp = 0;
      cy(6);
      chk(bm, 0);
      bt = 1;
      tp = 0;
      cy(6);
      chk(bm, 1);
      cy(100);
      chk(wdr, 0);
      chk(roe, 1);
      {wh, wl} = 2'h3;
      bt = 0;
      tp = 1;
      cy(6);
      chk(bm, 0);
      bss = 1;
      cy(6);
      chk(bm, 1);
      bbm = 0;
      bbp = 1;
      cy(6);
      chk(bm, 0);
      bss = 0;
   endtask
   task t_lvr;
      cy(1);
      nvb = 1;
      vr = 0;
      cy(6);
      chk(roe, 0);
      chk(ben, 0);
      chk(ab_seen, 1);
      chk(nva, 1);
      nvb = 0;
      cy(30);
      chk(roe, 0);
      chk(nva, 0);
      vr = 1;
      wt(1, 60);
      chk(n >= 20 && n <= 27, 1);
      cy(1);
      {bbm, bbp, bt, tp} = 4'hA;
      cy(6);
      vr = 0;
      cy(6);
      vr = 1;
      cy(40);
      chk(roe, 0);
      {bbm, bbp, bt, tp} = 4'h5;
      wt(1, 60);
      chk(n >= 20 && n <= 30, 1);
   endtask
   initial begin
      cy(3);
      rst = 0;
      chk(ben, 0);
      chk(nva, 0);
      chk(rno, 0);
      wt(1, 60);
      chk(n >= 20 && n <= 28, 1);
      t_wd;
      t_sw;
      t_lvr;
      summarize;
   end
endmodule
